// ### hdl/cbc_pkg.sv
// Purpose: Shared constants and types for the secondary cache bus control block
// Assumes: 250 MHz bus clock; pin levels as on the processor bus (mostly active low)
// Notes:   Timing counts derive from printed times and the clock rate
package cbc_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_MHZ      = 250;
	localparam int WAKE_US      = 4;                    // Active again after power-down
	localparam int WAKE_CYC     = WAKE_US * CLK_MHZ;    // 1000 cycles
	localparam int SRST_MIN_CYC = 8;                    // Soft reset settle, low bound
	localparam int SYNC_STAGES  = 2;
	localparam int SRST_FILT    = SRST_MIN_CYC - SYNC_STAGES;
	localparam int WAKE_W       = 10;
	localparam int SRST_W       = 4;

	// ==========================================================
	// Geometry
	localparam int LINE_W      = 4;                     // Line index width; a flush walks 16 lines
	localparam int BEAT_W      = 2;
	localparam logic [BEAT_W-1:0] BEAT_LAST  = 2'h3;    // Four-beat burst
	localparam logic [BEAT_W-1:0] BEAT_ZERO  = 2'h0;
	localparam logic [LINE_W-1:0] LINE_LAST  = 4'hF;
	localparam logic [LINE_W-1:0] LINE_ZERO  = 4'h0;
	localparam int NUM_CPU     = 4;

	// ==========================================================
	// Bus pins, raw levels, all asynchronous to the block
	typedef struct packed {
		logic               ts_n;        // transfer_start
		logic               ci_n;        // cache_inhibit_in
		logic               miss_inh_n;  // miss_fill_inhibit
		logic               tag_clr_n;   // tag_clear_in
		logic               upd_inh_n;   // update_inhibit_in
		logic               pwr_dn;      // power_down_in, high = low power
		logic               flush_n;     // flush_request_in
		logic               srst_n;      // soft_reset_in
		logic               bg_n;        // cache_bus_grant
		logic               dbg_n;       // cache_data_grant
		logic               tea_n;       // transfer_error_ack
		logic               burst_status_n;      // burst_status
		logic               wt_n;        // write_through_status
		logic [NUM_CPU-1:0] processor_bus_request_n;    // processor_bus_request
	} cbc_pins_t;

	// ==========================================================
	// Data state machine, Gray along the write-back path
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_AREQ  = 3'h1,
		ST_ATEN  = 3'h3,
		ST_DWAIT = 3'h2,
		ST_DATA  = 3'h6,
		ST_HIT   = 3'h4,
		ST_FCLR  = 3'h5
	} cbc_state_t;
endpackage : cbc_pkg

// ### hdl/cbc_ctrl.sv
// Purpose: Bus handshake and control of a look-aside secondary cache
// Assumes: One bus clock; all pins pass a two-stage synchroniser
// Notes:   rstn is the hard reset; soft reset only clears the data machine
//
// Operation
// [RULE1] Flush done shared line, only pulled low
// [RULE2] Global flag negated while we are master
// [RULE3] Hard reset held low sixteen clocks
// [RULE4] Bus request pin driven as output
// [RULE5] Wait address grant before address tenure
// [RULE6] Cache inhibit after start blocks linefill
// [RULE7] Claim asserted after start on hit
// [RULE8] Data tenure starts only after data grant
// [RULE9] Flush writes dirty lines, clears tags
// [RULE10] Miss inhibit blocks fills on misses
// [RULE11] Tag clear invalidates and holds reset
// [RULE12] Update inhibit freezes all internal state; only the data machine holds, the wake and soft reset counters run on
// [RULE13] Power-down blocks array; wake after 4us
// [RULE14] System stops clock during power-down
// [RULE15] Soft reset synchronised, resets data machine
// [RULE16] Burst status selects burst or single
// [RULE17] Data busy driven only after data grant
// [RULE18] Write-through strap disables copy-back
// [RULE19] Four processor requests ORed together
// [RULE20] Error acknowledge ends the data tenure
// [RULE21] Transfer ack driven per hit beat
`timescale 1ns/1ps
module cbc_ctrl
	import cbc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire cbc_pins_t         pins,
	input  wire logic              tag_hit,
	input  wire logic              line_dirty,
	output logic                   cache_bus_request_o,
	output logic                   cache_bus_request_oe,
	output logic                   global_snoop_flag_n,
	output logic                   hit_claim_out_n,
	output logic                   hit_claim_out_oe,
	output logic                   transfer_ack_o,
	output logic                   transfer_ack_oe,
	output logic                   data_bus_busy_o,
	output logic                   data_bus_busy_oe,
	output logic                   flush_complete_line_o,
	output logic                   flush_complete_line_oe,
	output logic                   line_fill_start,
	output logic                   copy_back_beat,
	output logic [LINE_W-1:0]      line_index,
	output logic                   tags_invalidate,
	output logic                   array_write_enable
);
	// ==========================================================
	// Pin synchroniser
	cbc_pins_t s1_r, s2_r;
	localparam cbc_pins_t PINS_REST = '{pwr_dn: 1'b0, default: '1}; // All negated, no false power-down

	// Two flops on every pin; only s2_r is read
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_r <= PINS_REST;
			s2_r <= PINS_REST;
		end else begin
			s1_r <= pins;
			s2_r <= s1_r;
		end
	end

	logic ts, ci, miss_inh, tclr, uinh, pdn, flush, bg, dbg, transfer_error_ack, burst, wt_mode, cpu_req;
	// Decoded active levels
	assign ts       = !s2_r.ts_n;
	assign ci       = !s2_r.ci_n;
	assign miss_inh = !s2_r.miss_inh_n;
	assign tclr     = !s2_r.tag_clr_n;
	assign uinh     = !s2_r.upd_inh_n;
	assign pdn      = s2_r.pwr_dn;
	assign flush    = !s2_r.flush_n;
	assign bg       = !s2_r.bg_n;
	assign dbg      = !s2_r.dbg_n;
	assign transfer_error_ack      = !s2_r.tea_n;
	assign burst    = !s2_r.burst_status_n;
	assign wt_mode  = !s2_r.wt_n;                  // Strapped low: write-through only [RULE18]
	assign cpu_req  = !(&s2_r.processor_bus_request_n);           // Any processor asking [RULE19]

	// ==========================================================
	// Soft reset filter
	logic [SRST_W-1:0] srst_cnt_r, srst_cnt_nxt;
	logic              srst_r, srst_nxt;

	// Soft reset must stay low SRST_FILT+1 clocks after sync
	always_comb begin
		srst_cnt_nxt = srst_cnt_r;
		srst_nxt     = srst_r;
		if (s2_r.srst_n) begin
			srst_cnt_nxt = '0;
			srst_nxt     = 1'b0;
		end else if (srst_cnt_r == SRST_W'(SRST_FILT)) begin
			srst_nxt = 1'b1;                       // [RULE15]
		end else begin
			srst_cnt_nxt = srst_cnt_r + SRST_W'(1);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			srst_cnt_r <= '0;
			srst_r     <= 1'b0;
		end else begin
			srst_cnt_r <= srst_cnt_nxt;
			srst_r     <= srst_nxt;
		end
	end

	// ==========================================================
	// Power-down wake timer
	logic [WAKE_W-1:0] wake_r, wake_nxt;
	logic              awe_nxt;

	// Reload during power-down, count down after release
	always_comb begin
		wake_nxt = wake_r;
		if (pdn)
			wake_nxt = WAKE_W'(WAKE_CYC);          // [RULE13]
		else if (wake_r != '0)
			wake_nxt = wake_r - WAKE_W'(1);
		awe_nxt = !pdn && (wake_r == '0) && !uinh;  // [RULE13]
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wake_r             <= '0;
			array_write_enable <= 1'b0;
		end else begin
			wake_r             <= wake_nxt;
			array_write_enable <= awe_nxt;
		end
	end

	// ==========================================================
	// Data state machine and bus outputs
	cbc_state_t        st_r, st_nxt;
	logic [BEAT_W-1:0] beat_r, beat_nxt, hit_last_r, hit_last_nxt;
	logic [LINE_W-1:0] idx_r, idx_nxt;
	logic              fl_act_r, fl_act_nxt;
	logic              br_nxt, gbl_nxt, clm_nxt, ta_nxt, dbb_nxt, fill_nxt, cbb_nxt, tinv_nxt;
	logic              active;

	assign active = !pdn && (wake_r == '0);

	// Next state, with reset holds ahead of the freeze
	always_comb begin
		st_nxt       = st_r;
		beat_nxt     = beat_r;
		hit_last_nxt = hit_last_r;
		idx_nxt      = idx_r;
		fl_act_nxt   = fl_act_r;
		br_nxt       = 1'b0;
		gbl_nxt      = 1'b0;
		clm_nxt      = 1'b0;
		ta_nxt       = 1'b0;
		dbb_nxt      = 1'b0;
		fill_nxt     = 1'b0;
		cbb_nxt      = 1'b0;
		tinv_nxt     = 1'b0;
		if (tclr || srst_r) begin
			st_nxt     = ST_IDLE;                  // [RULE11] [RULE15]
			beat_nxt   = BEAT_ZERO;
			idx_nxt    = LINE_ZERO;
			fl_act_nxt = 1'b0;
			tinv_nxt   = tclr;                     // [RULE11]
		end else if (uinh) begin
			st_nxt = st_r;                         // Frozen, bus ignored [RULE12]
		end else begin
			unique case (st_r)
				ST_IDLE: begin
					if (ts && tag_hit && !ci) begin
						st_nxt       = ST_HIT;
						clm_nxt      = 1'b1;       // [RULE7]
						ta_nxt       = 1'b1;       // [RULE21]
						beat_nxt     = BEAT_ZERO;
						hit_last_nxt = burst ? BEAT_LAST : BEAT_ZERO; // [RULE16]
					end else if (ts && !tag_hit) begin
						fill_nxt = !ci && !miss_inh && burst && active; // [RULE6] [RULE10]
					end else if (flush && !fl_act_r) begin
						fl_act_nxt = 1'b1;         // [RULE9]
						idx_nxt    = LINE_ZERO;
					end else if (fl_act_r && active) begin
						if (line_dirty && !wt_mode) begin
							st_nxt = ST_AREQ;      // [RULE9] [RULE18]
						end else if (idx_r == LINE_LAST) begin
							st_nxt = ST_FCLR;
						end else begin
							idx_nxt = idx_r + LINE_W'(1);
						end
					end
				end
				ST_AREQ: begin
					br_nxt = !cpu_req && !bg;      // [RULE4] [RULE19]
					if (bg && !cpu_req) begin
						st_nxt  = ST_ATEN;         // [RULE5]
						gbl_nxt = 1'b0;            // [RULE2]
					end
				end
				ST_ATEN: begin
					st_nxt = ST_DWAIT;
				end
				ST_DWAIT: begin
					if (dbg) begin
						st_nxt   = ST_DATA;        // [RULE8]
						dbb_nxt  = 1'b1;           // [RULE17]
						cbb_nxt  = 1'b1;
						beat_nxt = BEAT_ZERO;
					end
				end
				ST_DATA: begin
					if (transfer_error_ack || beat_r == BEAT_LAST) begin
						st_nxt  = (idx_r == LINE_LAST) ? ST_FCLR : ST_IDLE; // [RULE20]
						idx_nxt = idx_r + LINE_W'(1);
					end else begin
						beat_nxt = beat_r + BEAT_W'(1);
						dbb_nxt  = 1'b1;           // [RULE17]
						cbb_nxt  = 1'b1;
					end
				end
				ST_HIT: begin
					if (transfer_error_ack || beat_r == hit_last_r) begin
						st_nxt = ST_IDLE;          // [RULE20]
					end else begin
						beat_nxt = beat_r + BEAT_W'(1);
						ta_nxt   = 1'b1;           // [RULE21]
					end
				end
				ST_FCLR: begin
					tinv_nxt   = 1'b1;             // [RULE9]
					fl_act_nxt = 1'b0;             // Releases shared line [RULE1]
					idx_nxt    = LINE_ZERO;
					st_nxt     = ST_IDLE;
				end
				default: st_nxt = ST_IDLE;
			endcase
		end
	end

	// State and output registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_r                   <= ST_IDLE;
			beat_r                 <= BEAT_ZERO;
			hit_last_r             <= BEAT_ZERO;
			idx_r                  <= LINE_ZERO;
			fl_act_r               <= 1'b0;
			cache_bus_request_o    <= 1'b1;
			cache_bus_request_oe   <= 1'b1;
			global_snoop_flag_n    <= 1'b1;
			hit_claim_out_n        <= 1'b1;
			hit_claim_out_oe       <= 1'b0;
			transfer_ack_o         <= 1'b1;
			transfer_ack_oe        <= 1'b0;
			data_bus_busy_o        <= 1'b1;
			data_bus_busy_oe       <= 1'b0;
			flush_complete_line_o  <= 1'b0;
			flush_complete_line_oe <= 1'b0;
			line_fill_start        <= 1'b0;
			copy_back_beat         <= 1'b0;
			tags_invalidate        <= 1'b0;
		end else begin
			st_r                   <= st_nxt;
			beat_r                 <= beat_nxt;
			hit_last_r             <= hit_last_nxt;
			idx_r                  <= idx_nxt;
			fl_act_r               <= fl_act_nxt;
			cache_bus_request_o    <= !br_nxt;     // Active low, always driven [RULE4]
			cache_bus_request_oe   <= 1'b1;
			global_snoop_flag_n    <= !gbl_nxt;    // [RULE2]
			hit_claim_out_n        <= !clm_nxt;
			hit_claim_out_oe       <= clm_nxt;
			transfer_ack_o         <= !ta_nxt;
			transfer_ack_oe        <= ta_nxt;
			data_bus_busy_o        <= !dbb_nxt;
			data_bus_busy_oe       <= dbb_nxt;
			flush_complete_line_o  <= 1'b0;        // Only ever pulls low [RULE1]
			flush_complete_line_oe <= fl_act_nxt;
			line_fill_start        <= fill_nxt;
			copy_back_beat         <= cbb_nxt;
			tags_invalidate        <= tinv_nxt;
		end
	end

	assign line_index = idx_r;

	// ==========================================================
	// Checks
	property p_gbl_master;                               // [RULE2]
		@(posedge clk) disable iff (!rstn) (st_r inside {ST_ATEN, ST_DWAIT, ST_DATA}) |-> global_snoop_flag_n;
	endproperty
	a_gbl_master: assert property (p_gbl_master) else $error("global flag asserted while master"); // [RULE2]

	property p_br_driven;                                // [RULE4]
		@(posedge clk) disable iff (!rstn) cache_bus_request_oe;
	endproperty
	a_br_driven: assert property (p_br_driven) else $error("bus request not driven"); // [RULE4]

	property p_aten_grant;                               // [RULE5]
		@(posedge clk) disable iff (!rstn) (st_r == ST_AREQ && st_nxt == ST_ATEN) |-> bg;
	endproperty
	a_aten_grant: assert property (p_aten_grant) else $error("address tenure without grant"); // [RULE5]

	property p_dbb_grant;                                // [RULE8]
		@(posedge clk) disable iff (!rstn) $rose(data_bus_busy_oe) |-> $past(st_r) == ST_DWAIT && $past(dbg);
	endproperty
	a_dbb_grant: assert property (p_dbb_grant) else $error("data busy without data grant"); // [RULE8]

	property p_fill_blocked;                             // [RULE6]
		@(posedge clk) disable iff (!rstn) (ci || miss_inh) |=> !line_fill_start;
	endproperty
	a_fill_blocked: assert property (p_fill_blocked) else $error("fill despite inhibit"); // [RULE6]

	property p_claim_hit;                                // [RULE7]
		@(posedge clk) disable iff (!rstn)
			(st_r == ST_IDLE && ts && tag_hit && !ci && !uinh && !tclr && !srst_r) |=> !hit_claim_out_n && hit_claim_out_oe;
	endproperty
	a_claim_hit: assert property (p_claim_hit) else $error("hit not claimed"); // [RULE7]

	property p_tclr_hold;                                // [RULE11]
		@(posedge clk) disable iff (!rstn) tclr |=> st_r == ST_IDLE && tags_invalidate;
	endproperty
	a_tclr_hold: assert property (p_tclr_hold) else $error("tag clear not holding"); // [RULE11]

	property p_freeze;                                   // [RULE12]
		@(posedge clk) disable iff (!rstn) (uinh && !tclr && !srst_r) |=> $stable(st_r) && $stable(idx_r);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved under update inhibit"); // [RULE12]

	property p_wake;                                     // [RULE13]
		@(posedge clk) disable iff (!rstn) $fell(pdn) |-> !array_write_enable [*8];
	endproperty
	a_wake: assert property (p_wake) else $error("array enabled too soon after power-down"); // [RULE13]

	property p_tea_end;                                  // [RULE20]
		@(posedge clk) disable iff (!rstn) (st_r == ST_HIT && transfer_error_ack && !uinh && !tclr && !srst_r) |=> !transfer_ack_oe;
	endproperty
	a_tea_end: assert property (p_tea_end) else $error("beat after error acknowledge"); // [RULE20]

	c_hit: cover property (@(posedge clk) disable iff (!rstn) st_r == ST_HIT ##1 st_r == ST_IDLE);
	c_wb:  cover property (@(posedge clk) disable iff (!rstn) st_r == ST_DATA && beat_r == BEAT_LAST);
	c_fls: cover property (@(posedge clk) disable iff (!rstn) st_r == ST_FCLR);
endmodule : cbc_ctrl

// ### bench/cbc_partner.sv
// Purpose: Far-side model: arbiter grants and board pullups
// Assumes: Grants answer after a programmable delay
// Notes:   Released lines read high through pullups
`timescale 1ns/1ps
module cbc_partner
	import cbc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic [7:0] delay,
	input  wire logic       req_o,
	input  wire logic       req_oe,
	input  wire logic       claim_n,
	input  wire logic       claim_oe,
	input  wire logic       ta_o,
	input  wire logic       ta_oe,
	input  wire logic       dbb_o,
	input  wire logic       dbb_oe,
	input  wire logic       fdn_o,
	input  wire logic       fdn_oe,
	output logic            bg_n,
	output logic            dbg_n,
	output wire             req_w,
	output wire             claim_w,
	output wire             ta_w,
	output wire             dbb_w,
	output wire             fdn_w
);
	logic [7:0] cnt;
	logic       data_ph;

	// ==========================================================
	// Pullup resolution of shared lines
	assign req_w   = req_oe ? req_o : 1'b1;
	assign claim_w = claim_oe ? claim_n : 1'b1;
	assign ta_w    = ta_oe ? ta_o : 1'b1;
	assign dbb_w   = dbb_oe ? dbb_o : 1'b1;
	assign fdn_w   = fdn_oe ? fdn_o : 1'b1;

	// ==========================================================
	// Arbiter: address grant pulse, then data grant held to busy
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt     <= 8'h00;
			bg_n    <= 1'b1;
			dbg_n   <= 1'b1;
			data_ph <= 1'b0;
		end else begin
			bg_n <= 1'b1;
			if (!data_ph && !req_w) begin
				if (cnt >= delay) begin
					bg_n    <= 1'b0;
					data_ph <= 1'b1;
					cnt     <= 8'h00;
				end else cnt <= cnt + 8'h01;
			end else if (data_ph) begin
				if (!dbb_w) begin
					dbg_n   <= 1'b1;
					data_ph <= 1'b0;
				end else if (cnt >= delay) dbg_n <= 1'b0;
				else cnt <= cnt + 8'h01;
			end
		end
	end
endmodule : cbc_partner

// ### bench/testbench.sv
// Purpose: Self-checking bench for the cache bus control block
// Assumes: Inputs change on the falling edge
// Notes:   Pulse counters run on every rising edge
`timescale 1ns/1ps
module testbench;
	import cbc_pkg::*;
	localparam cbc_pins_t IDLE = cbc_pins_t'(17'h1F7FF);
	logic clk = 1'b0, clk_run = 1'b1, rstn = 1'b0, tag_hit = 1'b0, dirty_en = 1'b0, bg_n, dbg_n, dg_seen;
	logic [7:0] delay = 8'h02;
	cbc_pins_t drv = IDLE, pins;
	logic req_o, req_oe, gbl_n, claim_n, claim_oe, ta_o, ta_oe, dbb_o, dbb_oe, fdn_o, fdn_oe, fill, cb, inv, awe;
	logic [LINE_W-1:0] idx;
	wire req_w, claim_w, ta_w, dbb_w, fdn_w, line_dirty;
	int n_ta, n_claim, n_fill, n_cb, n_inv, n_dbb, n_req, n_fdn, n_gbl, n_early, mismatches = 0, checks = 0;
	int clr_seq = 0, clr_seen = 0;

	// Clock stops while clk_run is low
	always #2 clk = clk_run ? ~clk : clk;
	assign line_dirty = dirty_en && (idx == 4'h3);
	always_comb begin
		pins = drv;
		pins.bg_n = bg_n;
		pins.dbg_n = dbg_n;
	end

	cbc_ctrl dut_u (.clk(clk), .rstn(rstn), .pins(pins), .tag_hit(tag_hit), .line_dirty(line_dirty),
		.cache_bus_request_o(req_o), .cache_bus_request_oe(req_oe), .global_snoop_flag_n(gbl_n),
		.hit_claim_out_n(claim_n), .hit_claim_out_oe(claim_oe), .transfer_ack_o(ta_o), .transfer_ack_oe(ta_oe),
		.data_bus_busy_o(dbb_o), .data_bus_busy_oe(dbb_oe), .flush_complete_line_o(fdn_o),
		.flush_complete_line_oe(fdn_oe), .line_fill_start(fill), .copy_back_beat(cb), .line_index(idx),
		.tags_invalidate(inv), .array_write_enable(awe));
	cbc_partner partner_u (.clk(clk), .rstn(rstn), .delay(delay), .req_o(req_o), .req_oe(req_oe),
		.claim_n(claim_n), .claim_oe(claim_oe), .ta_o(ta_o), .ta_oe(ta_oe), .dbb_o(dbb_o), .dbb_oe(dbb_oe),
		.fdn_o(fdn_o), .fdn_oe(fdn_oe), .bg_n(bg_n), .dbg_n(dbg_n), .req_w(req_w), .claim_w(claim_w),
		.ta_w(ta_w), .dbb_w(dbb_w), .fdn_w(fdn_w));

	// ==========================================================
	// Pulse and level counters
	always @(posedge clk) begin
		if (clr_seen != clr_seq) begin
			{n_ta, n_claim, n_fill, n_cb, n_inv, n_dbb, n_req, n_fdn, n_gbl, n_early} = '0;
			dg_seen = 1'b0;
			clr_seen = clr_seq;
		end
		n_ta += int'(ta_w === 1'b0);
		n_claim += int'(claim_w === 1'b0);
		n_fill += int'(fill === 1'b1);
		n_cb += int'(cb === 1'b1);
		n_inv += int'(inv === 1'b1);
		n_dbb += int'(dbb_w === 1'b0);
		n_req += int'(req_w === 1'b0);
		n_fdn += int'(fdn_w === 1'b0);
		n_gbl += int'(gbl_n !== 1'b1);
		n_early += int'(cb === 1'b1 && !dg_seen);
		if (dbg_n === 1'b0) dg_seen = 1'b1;
	end

	// ==========================================================
	// Helpers
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask : step
	task automatic clr;
		clr_seq++;
	endtask : clr
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : final_report
	task automatic do_reset;
		rstn = 1'b0;
		drv = IDLE;
		step(16);
		rstn = 1'b1;
		step(2);
	endtask : do_reset
	task automatic wait_awe;
		int i;
		for (i = 0; i < 1100 && awe !== 1'b1; i++) step(1);
		if (awe !== 1'b1) begin
			check(awe, 1'b1);
			final_report();
		end
	endtask : wait_awe
	task automatic ts_pulse;
		drv.ts_n = 1'b0;
		step(1);
		drv.ts_n = 1'b1;
	endtask : ts_pulse

	// ==========================================================
	// Scenarios
	task automatic hit_case(input logic burst, ci, uinh, transfer_error_ack, input int exp_claim, exp_ta);
		clr();
		tag_hit = 1'b1;
		drv.burst_status_n = ~burst;
		drv.ci_n = ~ci;
		drv.upd_inh_n = ~uinh;
		ts_pulse();
		if (transfer_error_ack) begin
			step(2);
			drv.tea_n = 1'b0;
			step(1);
			drv.tea_n = 1'b1;
		end
		step(12);
		check(n_claim, exp_claim);
		check(n_ta, exp_ta);
		drv = IDLE;
		tag_hit = 1'b0;
		step(2);
	endtask : hit_case
	task automatic miss_case(input logic ci, minh, input int exp);
		clr();
		drv.burst_status_n = 1'b0;
		drv.ci_n = ~ci;
		drv.miss_inh_n = ~minh;
		ts_pulse();
		step(8);
		check(n_fill, exp);
		drv = IDLE;
		step(2);
	endtask : miss_case
	task automatic flush_case(input logic wt_n, input int exp_cb);
		int i;
		clr();
		dirty_en = 1'b1;
		drv.wt_n = wt_n;
		drv.processor_bus_request_n = 4'hB;
		drv.flush_n = 1'b0;
		step(2);
		drv.flush_n = 1'b1;
		step(40);
		check(n_req, 0);
		check(req_oe, 1'b1);
		check(int'(n_fdn > 0), 1);
		drv.processor_bus_request_n = 4'hF;
		for (i = 0; i < 600 && n_inv == 0; i++) step(1);
		if (n_inv == 0) begin
			check(n_inv, 1);
			final_report();
		end
		step(4);
		check(n_cb, exp_cb);
		check(n_dbb, exp_cb);
		check(n_early, 0);
		check(n_inv, 1);
		check(idx, 4'h0);
		check(fdn_w, 1'b1);
		check(n_gbl, 0);
		dirty_en = 1'b0;
		drv = IDLE;
	endtask : flush_case
	task automatic tag_clear_case;
		clr();
		drv.tag_clr_n = 1'b0;
		step(6);
		tag_hit = 1'b1;
		ts_pulse();
		step(6);
		check(inv, 1'b1);
		check(n_claim, 0);
		drv = IDLE;
		tag_hit = 1'b0;
		step(6);
	endtask : tag_clear_case
	task automatic power_case;
		drv.pwr_dn = 1'b1;
		step(20);
		check(awe, 1'b0);
		clk_run = 1'b0;
		#401;
		clk_run = 1'b1;
		step(2);
		check(awe, 1'b0);
		drv.pwr_dn = 1'b0;
		step(990);
		check(awe, 1'b0);
		step(20);
		check(awe, 1'b1);
	endtask : power_case
	task automatic soft_reset_case;
		clr();
		delay = 8'hC8;
		dirty_en = 1'b1;
		drv.flush_n = 1'b0;
		step(2);
		drv.flush_n = 1'b1;
		step(30);
		check(fdn_w, 1'b0);
		drv.srst_n = 1'b0;
		step(7);
		check(fdn_w, 1'b0);
		step(9);
		check(fdn_w, 1'b1);
		check(n_cb, 0);
		dirty_en = 1'b0;
		delay = 8'h02;
		do_reset();
	endtask : soft_reset_case

	// ==========================================================
	// Main sequence
	initial begin
		do_reset();
		check({req_o, req_oe, claim_w, ta_w, fdn_w, gbl_n}, 6'h3F);
		wait_awe();
		hit_case(1'b0, 1'b0, 1'b0, 1'b0, 1, 1);
		hit_case(1'b1, 1'b0, 1'b0, 1'b0, 1, 4);
		hit_case(1'b1, 1'b1, 1'b0, 1'b0, 0, 0);
		hit_case(1'b1, 1'b0, 1'b1, 1'b0, 0, 0);
		hit_case(1'b1, 1'b0, 1'b0, 1'b1, 1, 3);
		miss_case(1'b0, 1'b0, 1);
		miss_case(1'b1, 1'b0, 0);
		miss_case(1'b0, 1'b1, 0);
		flush_case(1'b1, 4);
		flush_case(1'b0, 0);
		tag_clear_case();
		power_case();
		soft_reset_case();
		wait_awe();
		hit_case(1'b1, 1'b0, 1'b0, 1'b0, 1, 4);
		final_report();
	end
endmodule : testbench
